// ### dv/bmirq_host_model.sv
// host side model that counts interrupt assertions
`timescale 1ns/1ps
module bmirq_host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_out_n,
   output logic [7:0] irq_count
);
   logic irq_last_reg;
   // counted per new assertion, so one long low and several short ones differ
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_last_reg <= 1'b1;
         irq_count <= 8'h00;
      end else begin
         irq_last_reg <= irq_out_n;
         if (irq_last_reg && !irq_out_n) begin
            irq_count <= irq_count + 8'h01;
         end
      end
   end
endmodule : bmirq_host_model

// ### dv/button_and_misc_irq_regs_tb_top.sv
// self-checking bench for the button and misc interrupt block
`timescale 1ns/1ps
module button_and_misc_irq_regs_tb_top import bmirq_pkg::*;;
   localparam int TK = 4;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic power_button_in = 1'b1;
   logic [4:0] ev = 5'h00;
   logic awready, wready, bvalid, arready, rvalid, irq_out_n;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] irq_count;
   logic [4:0] mval;
   logic [5:0] bval;
   logic [34:0] exp_q[$];
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 40;
   int falls = 0;
   int t_press = 0;
   // ****************************************
   // clock, design and host
   // ****************************************
   initial begin
      forever #50 aclk = ~aclk;
   end
   bmirq_top #(.TICK_CYCLES(TK)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .power_button_in(power_button_in), .wake_busy(ev[0]), .sleep_busy(ev[1]),
      .power_button_event(ev[2]), .power_button_level(ev[2]),
      .supply_low_level(ev[3]), .supply_ov_level(ev[4]), .irq_out_n(irq_out_n)
   );
   bmirq_host_model u_host (
      .aclk(aclk), .aresetn(aresetn), .irq_out_n(irq_out_n), .irq_count(irq_count)
   );
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic test_done;
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic irq_is(input logic e);
      chk({34'h0, irq_out_n}, {34'h0, e});
   endtask : irq_is
   // both channels offered together, each dropped once taken
   task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] r);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      exp_q.push_back({1'b1, r, 32'h0});
      awaddr <= {idx, 2'b00};
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awready) ad = 1'b1;
         if (wready) dd = 1'b1;
         if (ad) awvalid <= 1'b0;
         if (dd) wvalid <= 1'b0;
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] r);
      exp_q.push_back({1'b0, r, e});
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic ev_pulse(input int i);
      ev[i] <= 1'b1;
      repeat (2) @(posedge aclk);
      ev[i] <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : ev_pulse
   // responses are paired with the oldest note, one transfer at a time
   always @(posedge aclk) begin
      if (aresetn && bvalid && bready) chk({1'b1, bresp, 32'h0}, exp_q.pop_front());
      if (aresetn && rvalid && rready) chk({1'b0, rresp, rdata}, exp_q.pop_front());
   end
   // 8 s hold at four cycles a tick is about 32000 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         test_done;
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      irq_is(1'b1);
      rd(IDX_BTN_FLAGS, 32'h0, RESP_OKAY);
      rd(IDX_BTN_MASK, 32'h3F, RESP_OKAY);
      rd(IDX_MISC_FLAGS, 32'h0, RESP_OKAY);
      rd(IDX_DEB_CFG, 32'h1F1F, RESP_OKAY);
      wr(6'h3F, 32'hFFFFFFFF, RESP_SLVERR);
      rd(6'h3F, 32'h0, RESP_SLVERR);
      wr(IDX_BTN_LIVE, 32'hFF, RESP_OKAY);
      rd(IDX_BTN_LIVE, 32'h0, RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         mval = 5'($random(seed));
         wr(IDX_MISC_MASK, {27'h0, mval}, RESP_OKAY);
         ev_pulse(i);
         wr(IDX_MISC_FLAGS, 32'h0, RESP_OKAY);
         rd(IDX_MISC_FLAGS, 32'h1 << i, RESP_OKAY);
         rd(IDX_MISC_FLAGS, 32'h0, RESP_OKAY);
         ev_pulse(i);
         irq_is(mval[i]);
         // both pulses of an unmasked event reach the pin
         if (!mval[i]) falls += 2;
         wr(IDX_MISC_FLAGS, 32'h1 << i, RESP_OKAY);
         irq_is(1'b1);
         rd(IDX_MISC_FLAGS, 32'h0, RESP_OKAY);
      end
      bval = 6'($random(seed));
      wr(IDX_BTN_MASK, {26'h0, bval}, RESP_OKAY);
      rd(IDX_BTN_MASK, {26'h0, bval}, RESP_OKAY);
      wr(IDX_BTN_MASK, 32'h0, RESP_OKAY);
      // short debounce keeps the press and release margins small
      wr(IDX_DEB_CFG, 32'h0202, RESP_OKAY);
      power_button_in <= 1'b0;
      t_press = cyc;
      repeat (60) @(posedge aclk);
      irq_is(1'b0);
      rd(IDX_BTN_LIVE, 32'h1, RESP_OKAY);
      rd(IDX_BTN_FLAGS, 32'h1, RESP_OKAY);
      irq_is(1'b1);
      for (int k = 0; k < 5; k++) begin
         while (cyc < t_press + HOLD_TK[k] * TK + 60) @(posedge aclk);
         irq_is(1'b0);
         rd(IDX_BTN_LIVE, (32'h1 << (k + 2)) - 32'h1, RESP_OKAY);
         rd(IDX_BTN_FLAGS, 32'h2 << k, RESP_OKAY);
      end
      falls += 6;
      power_button_in <= 1'b1;
      repeat (60) @(posedge aclk);
      irq_is(1'b0);
      rd(IDX_BTN_LIVE, 32'h0, RESP_OKAY);
      rd(IDX_BTN_FLAGS, 32'h1, RESP_OKAY);
      falls++;
      // masked press and misc events latch but leave the pin high
      wr(IDX_BTN_MASK, 32'h3F, RESP_OKAY);
      wr(IDX_MISC_MASK, 32'h1F, RESP_OKAY);
      power_button_in <= 1'b0;
      ev <= 5'h1F;
      repeat (60) @(posedge aclk);
      irq_is(1'b1);
      rd(IDX_BTN_FLAGS, 32'h1, RESP_OKAY);
      rd(IDX_MISC_LIVE, 32'h1F, RESP_OKAY);
      rd(IDX_MISC_FLAGS, 32'h1C, RESP_OKAY);
      chk({27'h0, irq_count}, 35'(falls));
      test_done;
   end
endmodule : button_and_misc_irq_regs_tb_top

// ### rtl/bmirq_debounce.sv
// programmable debounce of the power button level, counted in millisecond ticks
`timescale 1ns/1ps
module bmirq_debounce import bmirq_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic raw_pressed,
   input wire logic [7:0] press_ms,
   input wire logic [7:0] release_ms,
   output logic press_level
);
   bmirq_db_state_t state_reg;
   logic [7:0] cnt_reg;
   // a bounce restarts the count, so only a steady level for the whole time flips
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= DB_RELEASED;
         cnt_reg <= 8'h00;
         press_level <= 1'b0;
      end else begin
         unique case (state_reg)
            DB_RELEASED: begin
               if (!raw_pressed) begin
                  cnt_reg <= 8'h00;
               end else if (tick) begin
                  if (cnt_reg >= press_ms) begin
                     state_reg <= DB_PRESSED;
                     press_level <= 1'b1;
                     cnt_reg <= 8'h00;
                  end else begin
                     cnt_reg <= 8'(cnt_reg + 8'h01);
                  end
               end
            end
            DB_PRESSED: begin
               if (raw_pressed) begin
                  cnt_reg <= 8'h00;
               end else if (tick) begin
                  if (cnt_reg >= release_ms) begin
                     state_reg <= DB_RELEASED;
                     press_level <= 1'b0;
                     cnt_reg <= 8'h00;
                  end else begin
                     cnt_reg <= 8'(cnt_reg + 8'h01);
                  end
               end
            end
         endcase
      end
   end
endmodule : bmirq_debounce

// ### rtl/bmirq_hold_timer.sv
// held-duration timer giving the one to eight second live bits
`timescale 1ns/1ps
module bmirq_hold_timer import bmirq_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic pressed,
   output logic [4:0] hold_live
);
   logic [HOLD_CW-1:0] cnt_reg;
   // saturates just past the longest threshold so the count never wraps
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else if (!pressed) begin
         cnt_reg <= '0;
      end else if (tick && cnt_reg <= HOLD_TK[4]) begin
         cnt_reg <= HOLD_CW'(cnt_reg + 1'b1);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_live <= 5'h00;
      end else begin
         for (int i = 0; i < 5; i++) begin
            hold_live[i] <= pressed && (cnt_reg >= HOLD_TK[i]);
         end
      end
   end
endmodule : bmirq_hold_timer

// ### rtl/bmirq_pkg.sv
// constants, types and address decode for the button and misc interrupt block
package bmirq_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int HOLD1_S = 1;
   localparam int HOLD2_S = 2;
   localparam int HOLD3_S = 3;
   localparam int HOLD4_S = 4;
   localparam int HOLD8_S = 8;
   localparam int HOLD_CW = 14;
   localparam logic [HOLD_CW-1:0] HOLD_TK [5] = '{
      HOLD_CW'(HOLD1_S * 1000 / TICK_MS), HOLD_CW'(HOLD2_S * 1000 / TICK_MS),
      HOLD_CW'(HOLD3_S * 1000 / TICK_MS), HOLD_CW'(HOLD4_S * 1000 / TICK_MS),
      HOLD_CW'(HOLD8_S * 1000 / TICK_MS)};
   // ****************************************
   // register map, index times four is the byte address
   // ****************************************
   localparam logic [5:0] IDX_BTN_FLAGS = 6'h24;
   localparam logic [5:0] IDX_BTN_MASK = 6'h25;
   localparam logic [5:0] IDX_BTN_LIVE = 6'h26;
   localparam logic [5:0] IDX_MISC_FLAGS = 6'h28;
   localparam logic [5:0] IDX_MISC_MASK = 6'h29;
   localparam logic [5:0] IDX_MISC_LIVE = 6'h2A;
   localparam logic [5:0] IDX_DEB_CFG = 6'h2C;
   localparam int BTN_W = 6;
   localparam int MISC_W = 5;
   localparam logic [BTN_W-1:0] BTN_MASK_RST = 6'h3F;
   localparam logic [MISC_W-1:0] MISC_MASK_RST = 5'h1F;
   localparam logic [7:0] DEB_PRESS_RST = 8'h1F;
   localparam logic [7:0] DEB_REL_RST = 8'h1F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {DB_RELEASED, DB_PRESSED} bmirq_db_state_t;
   function automatic logic [5:0] bmirq_idx(input logic [7:0] addr);
      return addr[7:2];
   endfunction : bmirq_idx
endpackage : bmirq_pkg

// ### rtl/bmirq_top.sv
// button and misc interrupt registers with an AXI4-Lite slave
// ****************************************
// Overview of operation
// - latch three, four, eight second hold flags
// - read or write one clears flags
// - flags reset zero and stay until cleared
// - six button mask bits, reset to one
// - unmasked set flag pulls interrupt low
// - masked flag latches but keeps interrupt high
// - press live bit follows debounced button
// - hold live bits drop on release
// - live bits one to five for thresholds
// - misc bit0 on wake transition done
// - misc bit1 on sleep transition done
// - misc bit2 on power button event
// - misc bit3 on supply low crossing
// - misc bit4 on overvoltage crossing
// - press flag on every press live change
// - latch one and two second hold flags
// ****************************************
`timescale 1ns/1ps
module bmirq_top import bmirq_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic power_button_in,
   input wire logic wake_busy,
   input wire logic sleep_busy,
   input wire logic power_button_event,
   input wire logic power_button_level,
   input wire logic supply_low_level,
   input wire logic supply_ov_level,
   output logic irq_out_n
);
   // ****************************************
   // millisecond tick
   // ****************************************
   logic [23:0] div_reg;
   logic tick;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_reg <= 24'h000000;
         tick <= 1'b0;
      end else if (div_reg == 24'(TICK_CYCLES - 1)) begin
         div_reg <= 24'h000000;
         tick <= 1'b1;
      end else begin
         div_reg <= 24'(div_reg + 24'h000001);
         tick <= 1'b0;
      end
   end

   // ****************************************
   // button sensing
   // ****************************************
   logic [7:0] deb_press_reg;
   logic [7:0] deb_rel_reg;
   logic press_live;
   logic [4:0] hold_live;
   bmirq_debounce u_debounce (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .raw_pressed(!power_button_in),
      .press_ms(deb_press_reg),
      .release_ms(deb_rel_reg),
      .press_level(press_live)
   );
   bmirq_hold_timer u_hold (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .pressed(press_live),
      .hold_live(hold_live)
   );

   // ****************************************
   // event edges
   // ****************************************
   logic press_prev_reg;
   logic [4:0] hold_prev_reg;
   logic wake_prev_reg;
   logic sleep_prev_reg;
   logic low_prev_reg;
   logic ov_prev_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         press_prev_reg <= 1'b0;
         hold_prev_reg <= 5'h00;
         wake_prev_reg <= 1'b0;
         sleep_prev_reg <= 1'b0;
         low_prev_reg <= 1'b0;
         ov_prev_reg <= 1'b0;
      end else begin
         press_prev_reg <= press_live;
         hold_prev_reg <= hold_live;
         wake_prev_reg <= wake_busy;
         sleep_prev_reg <= sleep_busy;
         low_prev_reg <= supply_low_level;
         ov_prev_reg <= supply_ov_level;
      end
   end
   logic [BTN_W-1:0] btn_set;
   logic [MISC_W-1:0] misc_set;
   assign btn_set[0] = press_live ^ press_prev_reg;
   assign btn_set[2:1] = hold_live[1:0] & ~hold_prev_reg[1:0];
   assign btn_set[5:3] = hold_live[4:2] & ~hold_prev_reg[4:2];
   assign misc_set[0] = wake_prev_reg & !wake_busy;
   assign misc_set[1] = sleep_prev_reg & !sleep_busy;
   assign misc_set[2] = power_button_event;
   // both crossing directions count, the live bit tells which side
   assign misc_set[3] = supply_low_level ^ low_prev_reg;
   assign misc_set[4] = supply_ov_level ^ ov_prev_reg;

   // ****************************************
   // AXI4-Lite write path
   // ****************************************
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   logic [5:0] wr_idx;
   logic wr_hit;
   assign awready = !aw_held_reg;
   assign wready = !w_held_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
   assign wr_idx = bmirq_idx(awaddr_reg);
   assign wr_hit = (wr_idx inside {IDX_BTN_FLAGS, IDX_BTN_MASK, IDX_BTN_LIVE,
      IDX_MISC_FLAGS, IDX_MISC_MASK, IDX_MISC_LIVE, IDX_DEB_CFG});
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg <= awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else if (wvalid && wready) begin
         w_held_reg <= 1'b1;
         wdata_reg <= wdata;
         wstrb_reg <= wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end
   logic wr_lane0;
   assign wr_lane0 = wr_fire && wstrb_reg[0];

   // ****************************************
   // AXI4-Lite read path
   // ****************************************
   logic rd_fire;
   logic [5:0] rd_idx;
   logic [31:0] rd_val;
   logic rd_hit;
   logic [BTN_W-1:0] btn_flags_reg;
   logic [BTN_W-1:0] btn_mask_reg;
   logic [MISC_W-1:0] misc_flags_reg;
   logic [MISC_W-1:0] misc_mask_reg;
   assign arready = !rvalid;
   assign rd_fire = arvalid && arready;
   assign rd_idx = bmirq_idx(araddr);
   always_comb begin
      rd_val = 32'h00000000;
      rd_hit = 1'b1;
      case (rd_idx)
         IDX_BTN_FLAGS: rd_val = 32'(btn_flags_reg);
         IDX_BTN_MASK: rd_val = 32'(btn_mask_reg);
         IDX_BTN_LIVE: rd_val = 32'({hold_live, press_live});
         IDX_MISC_FLAGS: rd_val = 32'(misc_flags_reg);
         IDX_MISC_MASK: rd_val = 32'(misc_mask_reg);
         IDX_MISC_LIVE: rd_val = 32'({supply_ov_level, supply_low_level,
            power_button_level, sleep_busy, wake_busy});
         IDX_DEB_CFG: rd_val = 32'({deb_rel_reg, deb_press_reg});
         default: rd_hit = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid <= 1'b1;
         rdata <= rd_val;
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ****************************************
   // sticky flags, set wins over clear
   // ****************************************
   logic [BTN_W-1:0] btn_clr;
   logic [BTN_W-1:0] btn_keep;
   logic [MISC_W-1:0] misc_clr;
   always_comb begin
      btn_clr = '0;
      misc_clr = '0;
      if (wr_lane0 && wr_idx == IDX_BTN_FLAGS) begin
         btn_clr = btn_clr | wdata_reg[BTN_W-1:0];
      end
      if (rd_fire && rd_idx == IDX_BTN_FLAGS) begin
         btn_clr = btn_clr | btn_flags_reg;
      end
      if (wr_lane0 && wr_idx == IDX_MISC_FLAGS) begin
         misc_clr = misc_clr | wdata_reg[MISC_W-1:0];
      end
      if (rd_fire && rd_idx == IDX_MISC_FLAGS) begin
         misc_clr = misc_clr | misc_flags_reg;
      end
   end
   assign btn_keep = btn_flags_reg & ~btn_clr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         btn_flags_reg <= '0;
         misc_flags_reg <= '0;
      end else begin
         btn_flags_reg <= btn_keep | btn_set;
         misc_flags_reg <= (misc_flags_reg & ~misc_clr) | misc_set;
      end
   end

   // ****************************************
   // writable configuration
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         btn_mask_reg <= BTN_MASK_RST;
         misc_mask_reg <= MISC_MASK_RST;
      end else if (wr_lane0 && wr_idx == IDX_BTN_MASK) begin
         btn_mask_reg <= wdata_reg[BTN_W-1:0];
      end else if (wr_lane0 && wr_idx == IDX_MISC_MASK) begin
         misc_mask_reg <= wdata_reg[MISC_W-1:0];
      end
   end
   // new debounce times apply at once, a count in flight is compared against them and is not restarted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deb_press_reg <= DEB_PRESS_RST;
         deb_rel_reg <= DEB_REL_RST;
      end else if (wr_fire && wr_idx == IDX_DEB_CFG) begin
         if (wstrb_reg[0]) begin
            deb_press_reg <= wdata_reg[7:0];
         end
         if (wstrb_reg[1]) begin
            deb_rel_reg <= wdata_reg[15:8];
         end
      end
   end

   // ****************************************
   // interrupt output
   // ****************************************
   logic pend_any;
   // masked flags still latch, only the pin is gated
   assign pend_any = |(btn_flags_reg & ~btn_mask_reg)
      || |(misc_flags_reg & ~misc_mask_reg);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= !pend_any;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence press_edge_s;
      $changed(press_live);
   endsequence
   sequence misc_read_s;
      rd_fire && rd_idx == IDX_MISC_FLAGS;
   endsequence
   sequence btn_w1c_s;
      wr_lane0 && wr_idx == IDX_BTN_FLAGS && wdata_reg[0] && !btn_set[0];
   endsequence

   hold_long_a: assert property ($rose(hold_live[4]) |=> btn_flags_reg[5])
      else $error("eight second hold not latched");
   w1c_clear_a: assert property (btn_w1c_s |=> !btn_flags_reg[0])
      else $error("write one did not clear press flag");
   read_clear_a: assert property (misc_read_s |=>
      (rdata[4:0] == $past(misc_flags_reg)) && ((misc_flags_reg & ~$past(misc_set)) == 5'h00))
      else $error("misc flags not cleared by read");
   set_wins_a: assert property ((btn_set != 6'h00) |=>
      ((btn_flags_reg & $past(btn_set)) == $past(btn_set)))
      else $error("event lost against clear");
   flag_sticky_a: assert property (1'b1 |=>
      ((btn_flags_reg & $past(btn_keep)) == $past(btn_keep)))
      else $error("flag dropped without clear");
   flag_quiet_a: assert property ((btn_flags_reg == 6'h00 && btn_set == 6'h00) |=>
      btn_flags_reg == 6'h00)
      else $error("flag set without event");
   mask_write_a: assert property ((wr_lane0 && wr_idx == IDX_BTN_MASK) |=>
      btn_mask_reg == $past(wdata_reg[5:0]))
      else $error("mask write not stored");
   irq_low_a: assert property (((btn_flags_reg & ~btn_mask_reg) != 6'h00)
      |=> !irq_out_n)
      else $error("unmasked flag did not pull irq low");
   irq_masked_a: assert property ((btn_flags_reg != 6'h00 &&
      (btn_flags_reg & ~btn_mask_reg) == 6'h00 && (misc_flags_reg & ~misc_mask_reg) == 5'h00)
      |=> irq_out_n)
      else $error("masked flag pulled irq low");
   press_tick_a: assert property ($changed(press_live) |-> $past(tick))
      else $error("press live moved off a debounce tick");
   hold_drop_a: assert property ($fell(press_live) |=> hold_live == 5'h00)
      else $error("hold live bits kept after release");
   hold_order_a: assert property ((hold_live & ~{hold_live[3:0], 1'b1}) == 5'h00)
      else $error("hold live bits out of order");
   wake_flag_a: assert property ($fell(wake_busy) |=> misc_flags_reg[0])
      else $error("wake completion not latched");
   low_flag_a: assert property ($changed(supply_low_level) |=> misc_flags_reg[3])
      else $error("supply low crossing not latched");
   press_flag_a: assert property (press_edge_s |=> btn_flags_reg[0])
      else $error("press change not latched");
   hold_short_a: assert property ($rose(hold_live[0]) |=> btn_flags_reg[1])
      else $error("one second hold not latched");
   irq_release_a: assert property (!pend_any ##1 !pend_any |=> irq_out_n)
      else $error("irq held low with nothing pending");
endmodule : bmirq_top
